// ==== core/rilm_top.sv ====
// regulator interrupt masks and buck load-current meter registers
// assumes a same-clock register port master; regulator conditions arrive asynchronous
// Function
// - reg1 pg-fall mask bit7 low lets pg loss raise pg flag; resets 1
// - reg1 pg-rise mask bit6 low lets pg gain raise pg flag; resets 1
// - reg1 current-limit mask bit4 low lets curlim raise flag; resets 0
// - reg0 pg-fall mask bit3 low lets pg loss raise pg flag; resets 1
// - reg0 pg-rise mask bit2 low lets pg gain raise pg flag; resets 1
// - reg0 current-limit mask bit0 low lets curlim raise flag; resets 0
// - masks gate only flags; status bits always follow conditions
// - selector bit0 picks buck0 (0) or buck1 (1); resets 0
// - every selector write with clock enable high starts a measurement on the written converter
// - result bit8 reads in high register bit0; upper bits read zero
// - result bits 7:0 read in low register; resets zero
// - result scaled 20 mA per count, full scale 10.22 A
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module rilm_top (
  // clock, reset, enable
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       CLK_EN_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // regulator conditions (asynchronous levels)
  input  wire logic [1:0] LIN_REG_PG_I,
  input  wire logic [1:0] LIN_REG_CURLIM_I,
  // measurement engine (same clock)
  output logic            MEAS_START_O,
  output logic            MEAS_BUCK_SEL_O,
  input  wire logic       MEAS_DONE_I,
  input  wire logic [8:0] MEAS_RESULT_I,
  // interrupt
  output logic            IRQ_O
);

  // ****************************************
  // input synchronisation
  // ****************************************
  rilm_pkg::rilm_bus_s  bus;
  rilm_pkg::rilm_cond_s cond_sync;
  rilm_pkg::rilm_cond_s cond_q;

  assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  rilm_sync2 #(.W(4)) u_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (RESET_I),
    .ce_i  (CLK_EN_I),
    .d_i   ({LIN_REG_PG_I, LIN_REG_CURLIM_I}),
    .q_o   (cond_sync)
  );

  // ****************************************
  // address decode
  // ****************************************
  wire sel_mask  = bus.addr == rilm_pkg::LIN_REG_IRQ_MASKS_ADDR;
  wire sel_msel  = bus.addr == rilm_pkg::LOAD_METER_SEL_ADDR;
  wire sel_hi    = bus.addr == rilm_pkg::LOAD_CUR_HIGH_ADDR;
  wire sel_lo    = bus.addr == rilm_pkg::LOAD_CUR_LOW_ADDR;
  wire sel_stat  = bus.addr == rilm_pkg::LIN_REG_STATUS_ADDR;
  wire sel_flags = bus.addr == rilm_pkg::LIN_REG_IRQ_FLAGS_ADDR;
  wire sel_ien   = bus.addr == rilm_pkg::IRQ_ENABLE_ADDR;
  wire wr_mask   = bus.wr && sel_mask;
  wire wr_msel   = bus.wr && sel_msel;
  wire wr_flags  = bus.wr && sel_flags;
  wire wr_ien    = bus.wr && sel_ien;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] mask_q;
  logic [7:0] msel_q;
  logic [8:0] result_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] ien_q;
  logic [7:0] rdata_d;

  wire [7:0] mask_d = bus.wdata & rilm_pkg::MASK_WR_BITS;

  // ****************************************
  // edge arming
  // ****************************************
  // reset zeros in the sync stages would fake an edge on a pin that idles high
  logic [1:0] arm_q;
  wire        edges_armed = arm_q == rilm_pkg::EDGE_ARM_CNT;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      arm_q <= 2'h0;
    end else if (CLK_EN_I && !edges_armed) begin
      arm_q <= arm_q + 2'h1;
    end
  end

  wire [1:0] pg_rise = cond_sync.pg & ~cond_q.pg & {2{edges_armed}};
  wire [1:0] pg_fall = ~cond_sync.pg & cond_q.pg & {2{edges_armed}};
  wire [1:0] cl_rise = cond_sync.curlim & ~cond_q.curlim & {2{edges_armed}};

  wire ev_lr0_pg = (pg_fall[0] && !mask_q[rilm_pkg::LR0_PG_FALL_BIT]) ||
                   (pg_rise[0] && !mask_q[rilm_pkg::LR0_PG_RISE_BIT]);
  wire ev_lr1_pg = (pg_fall[1] && !mask_q[rilm_pkg::LR1_PG_FALL_BIT]) ||
                   (pg_rise[1] && !mask_q[rilm_pkg::LR1_PG_RISE_BIT]);
  wire ev_lr0_cl = cl_rise[0] && !mask_q[rilm_pkg::LR0_CURLIM_BIT];
  wire ev_lr1_cl = cl_rise[1] && !mask_q[rilm_pkg::LR1_CURLIM_BIT];
  wire [3:0] events = {ev_lr1_cl, ev_lr0_cl, ev_lr1_pg, ev_lr0_pg};

  // set wins over write-one-to-clear
  wire [3:0] flag_clr = wr_flags ? bus.wdata[3:0] : 4'h0;
  assign flags_d = (flags_q & ~flag_clr) | events;

  wire [7:0] status_rd = {4'h0, cond_sync.curlim, cond_sync.pg};

  // read mux; unmapped reads return zero
  always_comb begin
    rdata_d = 8'h00;
    if (sel_mask) begin
      rdata_d = mask_q;
    end else if (sel_msel) begin
      rdata_d = msel_q;
    end else if (sel_hi) begin
      rdata_d = {7'h00, result_q[8]};
    end else if (sel_lo) begin
      rdata_d = result_q[7:0];
    end else if (sel_stat) begin
      rdata_d = status_rd;
    end else if (sel_flags) begin
      rdata_d = {4'h0, flags_q};
    end else if (sel_ien) begin
      rdata_d = {4'h0, ien_q};
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      mask_q <= rilm_pkg::MASK_RESET;
      ien_q  <= rilm_pkg::IRQ_EN_RESET;
    end else if (CLK_EN_I) begin
      if (wr_mask) begin
        mask_q <= mask_d;
      end
      if (wr_ien) begin
        ien_q <= bus.wdata[3:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      msel_q       <= rilm_pkg::SEL_RESET;
      MEAS_START_O <= 1'b0;
    end else if (CLK_EN_I) begin
      MEAS_START_O <= wr_msel;
      if (wr_msel) begin
        msel_q <= bus.wdata;
      end
    end
  end
  assign MEAS_BUCK_SEL_O = msel_q[rilm_pkg::SEL_BUCK_BIT];

  // counts pass unscaled, 20 mA each; atomic update
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      result_q <= rilm_pkg::RESULT_RESET;
    end else if (CLK_EN_I && MEAS_DONE_I) begin
      result_q <= MEAS_RESULT_I;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      cond_q  <= '0;
      flags_q <= rilm_pkg::FLAGS_RESET;
      IRQ_O   <= 1'b0;
      RDATA_O <= 8'h00;
    end else if (CLK_EN_I) begin
      cond_q  <= cond_sync;
      flags_q <= flags_d;
      IRQ_O   <= |(flags_d & ien_q);
      RDATA_O <= bus.rd ? rdata_d : 8'h00;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  // one request cycle each; the properties below build on them
  sequence s_mask_wr;
    CLK_EN_I && wr_mask;
  endsequence

  sequence s_sel_wr;
    CLK_EN_I && wr_msel;
  endsequence

  sequence s_rd_hi;
    CLK_EN_I && bus.rd && sel_hi;
  endsequence

  sequence s_rd_lo;
    CLK_EN_I && bus.rd && sel_lo;
  endsequence

  sequence s_rd_stat;
    CLK_EN_I && bus.rd && sel_stat;
  endsequence

  // ****************************************
  // event gating, both mask settings
  // ****************************************
  lr1_fall_gate_a: assert property (CLK_EN_I && pg_fall[1] && !mask_q[7] && !wr_flags |=> flags_q[1])
    else $error("reg1 pg fall did not flag");
  lr1_fall_block_a: assert property (CLK_EN_I && pg_fall[1] && mask_q[7] && !flags_q[1]
    |=> !flags_q[1])
    else $error("masked reg1 pg fall flagged");
  lr1_rise_gate_a: assert property (CLK_EN_I && pg_rise[1] && !mask_q[6] |=> flags_q[1])
    else $error("reg1 pg rise did not flag");
  lr1_rise_block_a: assert property (CLK_EN_I && pg_rise[1] && mask_q[6] && !flags_q[1] && !wr_flags
    |=> !flags_q[1])
    else $error("masked reg1 pg rise flagged");
  lr1_curlim_a: assert property (CLK_EN_I && cl_rise[1] && !mask_q[4] |=> flags_q[3])
    else $error("reg1 curlim did not flag");
  lr1_curlim_blk_a: assert property (CLK_EN_I && cl_rise[1] && mask_q[4] && !flags_q[3] |=> !flags_q[3])
    else $error("masked reg1 curlim flagged");
  lr0_fall_gate_a: assert property (CLK_EN_I && pg_fall[0] && !mask_q[3] |=> flags_q[0])
    else $error("reg0 pg fall did not flag");
  lr0_fall_block_a: assert property (CLK_EN_I && pg_fall[0] && mask_q[3] && !flags_q[0]
    |=> !flags_q[0])
    else $error("masked reg0 pg fall flagged");
  lr0_rise_gate_a: assert property (CLK_EN_I && pg_rise[0] && !mask_q[2] |=> flags_q[0])
    else $error("reg0 pg rise did not flag");
  lr0_rise_block_a: assert property (CLK_EN_I && pg_rise[0] && mask_q[2] && !flags_q[0]
    |=> !flags_q[0])
    else $error("masked reg0 pg rise flagged");
  lr0_curlim_a: assert property (CLK_EN_I && cl_rise[0] && !mask_q[0] |=> flags_q[2])
    else $error("reg0 curlim did not flag");
  lr0_curlim_blk_a: assert property (CLK_EN_I && cl_rise[0] && mask_q[0] && !flags_q[2] |=> !flags_q[2])
    else $error("masked reg0 curlim flagged");
  status_free_a: assert property (s_rd_stat
    |=> RDATA_O == {4'h0, $past(cond_sync.curlim), $past(cond_sync.pg)})
    else $error("status read not tracking conditions");

  // ****************************************
  // flags and interrupt
  // ****************************************
  flag_sticky_a: assert property (CLK_EN_I |=> (($past(flags_q) & ~$past(flag_clr)) & ~flags_q) == 4'h0)
    else $error("flag dropped without a clear");
  // a clear in the event cycle must not lose the event
  set_wins_a: assert property (CLK_EN_I && wr_flags |=> (flags_q & $past(events)) == $past(events))
    else $error("clear beat a same-cycle event");
  irq_level_a: assert property (CLK_EN_I |=> IRQ_O == |(flags_q & $past(ien_q)))
    else $error("interrupt level wrong");

  // ****************************************
  // register port and measurement
  // ****************************************
  sel_drive_a: assert property (s_sel_wr |=> MEAS_BUCK_SEL_O == $past(bus.wdata[0]))
    else $error("buck select not taken");
  sel_store_a: assert property (s_sel_wr |=> msel_q == $past(bus.wdata))
    else $error("selector byte not stored");
  meas_start_a: assert property (s_sel_wr |=> MEAS_START_O)
    else $error("measurement start missing");
  meas_quiet_a: assert property (CLK_EN_I && !wr_msel |=> !MEAS_START_O)
    else $error("measurement start without write");
  hi_read_a: assert property (s_rd_hi |=> RDATA_O == {7'h00, $past(result_q[8])})
    else $error("high result read wrong");
  lo_read_a: assert property (s_rd_lo |=> RDATA_O == $past(result_q[7:0]))
    else $error("low result read wrong");
  rdata_idle_a: assert property (CLK_EN_I && !bus.rd |=> RDATA_O == 8'h00)
    else $error("read data outside read cycle");
  mask_rsv_a: assert property (s_mask_wr |=> (mask_q[5] == 1'b0) && (mask_q[1] == 1'b0))
    else $error("reserved mask bits stored");

  result_take_a: assert property (CLK_EN_I && MEAS_DONE_I |=> result_q == $past(MEAS_RESULT_I))
    else $error("result not captured on done");
  result_hold_a: assert property (!MEAS_DONE_I |=> $stable(result_q))
    else $error("result changed without done");

  // enable low must freeze even the read and pulse outputs
  freeze_hold_a: assert property (!CLK_EN_I |=> $stable(mask_q) && $stable(msel_q) && $stable(ien_q)
    && $stable(flags_q) && $stable(result_q) && $stable(RDATA_O)
    && $stable(IRQ_O) && $stable(MEAS_START_O))
    else $error("state moved with enable low");

endmodule
`default_nettype wire

// ==== core/rilm_pkg.sv ====
// package for the regulator interrupt mask and load meter register block
// assumes one core clock domain and byte-wide registers behind a plain port
package rilm_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] LIN_REG_IRQ_MASKS_ADDR = 8'h23;
  localparam logic [7:0] LOAD_METER_SEL_ADDR    = 8'h24;
  localparam logic [7:0] LOAD_CUR_HIGH_ADDR     = 8'h25;
  localparam logic [7:0] LOAD_CUR_LOW_ADDR      = 8'h26;
  localparam logic [7:0] LIN_REG_STATUS_ADDR    = 8'h27;
  localparam logic [7:0] LIN_REG_IRQ_FLAGS_ADDR = 8'h28;
  localparam logic [7:0] IRQ_ENABLE_ADDR        = 8'h29;

  // ****************************************
  // field positions
  // ****************************************
  localparam int LR1_PG_FALL_BIT = 7;
  localparam int LR1_PG_RISE_BIT = 6;
  localparam int LR1_CURLIM_BIT  = 4;
  localparam int LR0_PG_FALL_BIT = 3;
  localparam int LR0_PG_RISE_BIT = 2;
  localparam int LR0_CURLIM_BIT  = 0;
  localparam int FLAG_LR0_PG     = 0;
  localparam int FLAG_LR1_PG     = 1;
  localparam int FLAG_LR0_CURLIM = 2;
  localparam int FLAG_LR1_CURLIM = 3;
  localparam int SEL_BUCK_BIT    = 0;

  // ****************************************
  // reset values and widths
  // ****************************************
  localparam logic [7:0] MASK_WR_BITS   = 8'hDD;
  localparam logic [7:0] MASK_RESET     = 8'hCC;
  localparam logic [7:0] SEL_RESET      = 8'h00;
  localparam logic [8:0] RESULT_RESET   = 9'h000;
  localparam logic [3:0] FLAGS_RESET    = 4'h0;
  localparam logic [3:0] IRQ_EN_RESET   = 4'h0;
  localparam logic [1:0] EDGE_ARM_CNT   = 2'h3;
  localparam int         RESULT_W       = 9;
  localparam int         LSB_MA         = 20;
  localparam int         FULL_SCALE_MA  = 10220;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rilm_bus_s;

  typedef struct packed {
    logic [1:0] pg;
    logic [1:0] curlim;
  } rilm_cond_s;

endpackage

// ==== core/rilm_sync2.sv ====
// two-flop synchroniser, one bit per lane
// assumes the inputs are asynchronous levels from the analog side
`timescale 1ns/100ps
`default_nettype none
module rilm_sync2 #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_regulator_irq_mask_load_meter.sv ====
// bench for the regulator irq mask and load meter registers
// assumes rilm_top alone; the bench plays bus master, pins and meter
`timescale 1ns/100ps
`default_nettype none
module tb_regulator_irq_mask_load_meter;
  localparam logic [7:0] MSK = rilm_pkg::LIN_REG_IRQ_MASKS_ADDR;
  localparam logic [7:0] SEL = rilm_pkg::LOAD_METER_SEL_ADDR;
  localparam logic [7:0] HI  = rilm_pkg::LOAD_CUR_HIGH_ADDR;
  localparam logic [7:0] LO  = rilm_pkg::LOAD_CUR_LOW_ADDR;
  localparam logic [7:0] STA = rilm_pkg::LIN_REG_STATUS_ADDR;
  localparam logic [7:0] FLG = rilm_pkg::LIN_REG_IRQ_FLAGS_ADDR;
  localparam logic [7:0] IEN = rilm_pkg::IRQ_ENABLE_ADDR;
  logic       clk, rst, en, wr, rd, start, bsel, done, irq;
  logic [7:0] addr, wdata, rdata, got, v;
  logic [1:0] pg, curlim;
  logic [8:0] res, r;
  logic [3:0] cv;
  int         error_cnt, compares, cyc;
  // event table: pin, level before, mask bit, flag bit
  int         pin_t [6] = '{0, 0, 1, 1, 2, 3};
  logic [5:0] pre_t     = 6'b000101;
  int         mb_t  [6] = '{3, 2, 7, 6, 0, 4};
  int         fb_t  [6] = '{0, 0, 1, 1, 2, 3};

  rilm_top rilm_top_i (
    .CORE_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(en), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .LIN_REG_PG_I(pg), .LIN_REG_CURLIM_I(curlim), .MEAS_START_O(start),
    .MEAS_BUCK_SEL_O(bsel), .MEAS_DONE_I(done), .MEAS_RESULT_I(res), .IRQ_O(irq));

  // ****************************************
  // checks and bus tasks
  // ****************************************
  function automatic logic [7:0] mask_rd(input logic [7:0] d);
    return d & 8'hDD;
  endfunction
  function automatic logic [7:0] hi_rd(input logic [8:0] d);
    return {7'h00, d[8]};
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // a gap cycle between strobes keeps each strobe to one assignment per step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
    chk8(got, e);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // clock, timeout, sequence
  // ****************************************
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    clk = 0; rst = 1; en = 1; wr = 0; rd = 0; addr = 0; wdata = 0; done = 0; res = 0;
    pg = 2'b11; curlim = 2'b00; cv = 4'b0011;
    error_cnt = 0; compares = 0; cyc = 0;
    void'($urandom(32'h8987d1d5));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(MSK, 8'hCC);
    rd_chk(SEL, 8'h00);
    rd_chk(HI, 8'h00);
    rd_chk(LO, 8'h00);
    rd_chk(8'h40, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      wr_reg(MSK, v);
      rd_chk(MSK, mask_rd(v));
    end
    for (int i = 0; i < 6; i++) begin
      v = {7'($urandom), i[0]};
      wr_reg(SEL, v);
      chk1(start, 1'b1);
      chk1(bsel, v[0]);
      @(posedge clk) #1 chk1(start, 1'b0);
      rd_chk(SEL, v);
    end
    // enable low: a selector write must neither land nor start a measurement
    @(posedge clk) en <= 1'b0;
    wr_reg(SEL, ~v);
    chk1(start, 1'b0);
    @(posedge clk) en <= 1'b1;
    rd_chk(SEL, v);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 9'h1FF : 9'($urandom);
      @(posedge clk);
      done <= 1'b1;
      res <= r;
      @(posedge clk);
      done <= 1'b0;
      res <= ~r;
      wr_reg(HI, 8'hFF);
      rd_chk(HI, hi_rd(r));
      rd_chk(LO, r[7:0]);
    end
    // second reset in mid-run restores every default
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(MSK, 8'hCC);
    rd_chk(SEL, 8'h00);
    rd_chk(HI, 8'h00);
    rd_chk(LO, 8'h00);
    wr_reg(IEN, 8'h0F);
    for (int i = 0; i < 6; i++) begin
      wr_reg(MSK, 8'hDD);
      cv[pin_t[i]] = pre_t[i];
      @(posedge clk) {curlim, pg} <= cv;
      settle();
      wr_reg(FLG, 8'h0F);
      wr_reg(MSK, 8'hDD & ~(8'h01 << mb_t[i]));
      cv[pin_t[i]] = ~pre_t[i];
      @(posedge clk) {curlim, pg} <= cv;
      settle();
      chk1(irq, 1'b1);
      rd_chk(FLG, 8'h01 << fb_t[i]);
      rd_chk(STA, {4'h0, cv});
      wr_reg(IEN, 8'h00);
      @(posedge clk) #1 chk1(irq, 1'b0);
      wr_reg(IEN, 8'h0F);
      @(posedge clk) #1 chk1(irq, 1'b1);
      wr_reg(FLG, 8'h01 << fb_t[i]);
      @(posedge clk) #1 chk1(irq, 1'b0);
      wr_reg(MSK, 8'hDD);
      cv[pin_t[i]] = pre_t[i];
      @(posedge clk) {curlim, pg} <= cv;
      settle();
      rd_chk(FLG, 8'h00);
      rd_chk(STA, {4'h0, cv});
    end
    final_report();
  end
endmodule
`default_nettype wire
